// ---- inc/slc_pkg.sv ----
`default_nettype none
package slc_pkg;

   // ****************************************************************
   // Register map and bus width
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;  // Debug control zero.
   localparam logic [7:0] REG_FIRST_DATA_ADDRESS_COMPARE = 8'h04;  // First compare address.
   localparam logic [7:0] REG_SECOND_DATA_ADDRESS_COMPARE = 8'h08;  // Second compare address.
   localparam logic [7:0] REG_STAT = 8'h0C;  // Status flags, write one clears.
   localparam logic [7:0] REG_DVC = 8'h10;   // Data value for compares.
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] DAC_RST = 32'h0000_0000;
   localparam logic [4:0] STAT_RST = 5'h00;

   // ****************************************************************
   // Control field positions, per resource n add the resource index
   // ****************************************************************
   localparam int C_EN = 0;       // Bits 1:0, compare enable.
   localparam int C_RD = 2;       // Bits 3:2, match loads.
   localparam int C_WR = 4;       // Bits 5:4, match stores.
   localparam int C_SL = 6;       // Bits 7:6, used for stack limits.
   localparam int C_HW = 8;       // Bits 9:8, owned by hardware.
   localparam int C_SUP = 10;     // Bits 11:10, supervisor accesses.
   localparam int C_USR = 12;     // Bits 13:12, user accesses.
   localparam int C_EVT = 14;     // Compare events enabled.
   localparam int C_WP = 15;      // Produce a watchpoint.
   localparam int C_HALT = 16;    // Enter debug halted mode.
   localparam int C_EDM = 17;     // External debug mode bit.
   localparam int C_IDM = 18;     // Internal debug mode bit.
   localparam int C_RANGE = 19;   // Match the inclusive address set.
   localparam int C_DVAL = 20;    // Also match the data value.

   // ****************************************************************
   // Status field positions
   // ****************************************************************
   localparam int S_INT = 0;      // Bits 1:0, debug status compare.
   localparam int S_EXT = 2;      // Bits 3:2, external status compare.
   localparam int S_SWV = 4;      // Software stack violation seen.

   // One load or store presented by the pipeline.
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] pc;
      logic is_store;
      logic supervisor;
      logic base_r1;      // Stack pointer gpr is base or index.
      logic mc_mode;      // Processor mode picks machine check.
   } slc_ls_t;

endpackage : slc_pkg
`default_nettype wire

// ---- verification/slc_pipe_model.sv ----
`default_nettype none

// Load and store pipeline on the far side of the stack limit checker.
module slc_pipe_model (
   // Clock.
   input wire logic i_clk_sys,
   // Access towards the checker.
   output slc_pkg::slc_ls_t o_ls,
   output logic o_ls_done,
   output logic o_hi_pend
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Idle state
   // ****************************************************************
   // Nothing is pending at time zero; no higher priority exception.
   initial begin
      o_ls = '0;
      o_ls_done = 1'b0;
      o_hi_pend = 1'b0;
   end

   // ****************************************************************
   // One access
   // ****************************************************************
   // A slow completion lands gap cycles after the access; released
   // fields show the inverse so stale values cannot pass for a match.
   task automatic access(input logic [31:0] a, d, pc,
                         input logic st, sup, r1, mc, input int gap);
      slc_pkg::slc_ls_t v;
      slc_pkg::slc_ls_t idle;
      v = '{valid: 1'b1, addr: a, data: d, pc: pc, is_store: st,
            supervisor: sup, base_r1: r1, mc_mode: mc};
      idle = ~v;
      idle.valid = 1'b0;
      @(posedge i_clk_sys);
      o_ls <= v;
      o_ls_done <= (gap == 0);
      for (int k = 0; k < gap; k++) begin
         @(posedge i_clk_sys);
         o_ls <= idle;
         o_ls_done <= (k == gap - 1);
      end
      @(posedge i_clk_sys);
      o_ls <= idle;
      o_ls_done <= 1'b0;
   endtask : access

endmodule : slc_pipe_model
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none

// Self-checking bench for the stack limit checker.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clk = 1'b0, srst = 1'b1, we = 1'b0, re = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, spc, a1, a2, rv;
   slc_pkg::slc_ls_t ls;
   logic done, hip, ab_o, dsi, mchk, evt, halt, wp, dirq;
   int n_mismatch = 0;
   int n_compared = 0;
   localparam logic [31:0] HX = (32'h1 << slc_pkg::C_EVT) |
      (32'h1 << slc_pkg::C_WP) | (32'h1 << slc_pkg::C_HALT) |
      (32'h1 << slc_pkg::C_EDM);
   localparam logic [31:0] INTERNAL_DEBUG_MODE_BIT = 32'h1 << slc_pkg::C_IDM;

   // Clock at 250 MHz.
   always #2 clk = ~clk;

   slc_pipe_model slc_pipe_model_inst (.i_clk_sys(clk), .o_ls(ls),
      .o_ls_done(done), .o_hi_pend(hip));

   slc_stack_limit_checker slc_stack_limit_checker_inst (
      .i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_we(we), .i_re(re), .o_rdata(rdata), .i_ls(ls), .i_ls_done(done),
      .i_hi_pend(hip), .o_abort(ab_o), .o_dsi(dsi), .o_mchk(mchk),
      .o_mc_saved_pc(spc), .o_dac_event(evt), .o_halt_req(halt),
      .o_watchpoint(wp), .o_debug_irq(dirq));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Control bits for stack use of resource n.
   function automatic logic [31:0] rs(input int n, input bit hw, sup, usr);
      rs = ((32'h1 << slc_pkg::C_EN) | (32'h1 << slc_pkg::C_RD) |
         (32'h1 << slc_pkg::C_WR) | (32'h1 << slc_pkg::C_SL) |
         (32'(hw) << slc_pkg::C_HW) | (32'(sup) << slc_pkg::C_SUP) |
         (32'(usr) << slc_pkg::C_USR)) << n;
   endfunction : rs

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // One access under a control word, then its responses and status.
   task automatic run(input logic [31:0] c, a, input bit sup, r1, ab, ev);
      logic [31:0] pc;
      bit mc;
      int gap;
      pc = $urandom;
      mc = 1'($urandom_range(1));
      gap = ev ? $urandom_range(2) : 0;
      wr(slc_pkg::REG_CTRL, c);
      slc_pipe_model_inst.access(a, $urandom, pc, 1'($urandom_range(1)),
         sup, r1, mc, gap);
      #1;
      chk(32'(ab_o), 32'(ab));
      chk(32'(dsi), 32'(ab & !mc));
      chk(32'(mchk), 32'(ab & mc));
      if (ab && mc) chk(spc, pc);
      chk(32'(evt), 32'(ev));
      chk(32'(halt), 32'(ev));
      chk(32'(wp), 32'(ev));
      chk(32'(dirq), 32'h0);
      rd(slc_pkg::REG_STAT, rv);
      chk(32'(rv[4:0]), 32'({ab, 1'b0, ev, 2'b00}));
      wr(slc_pkg::REG_STAT, 32'h0000_001F);
      $display("test done at %0t", $time);
   endtask : run

   task automatic results;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [7:0] map [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
      void'($urandom(59576));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      // Reset values, and an unmapped place that reads zero.
      foreach (map[i]) begin
         rd(map[i], rv);
         chk(rv, 32'h0000_0000);
      end
      wr(slc_pkg::REG_CTRL, 32'h0000_003C);
      rd(slc_pkg::REG_CTRL, rv);
      chk(rv, 32'h0000_003C);
      a1 = $urandom & 32'hFFFF_FFF0;
      a2 = a1 + 32'h0000_0100;
      wr(slc_pkg::REG_FIRST_DATA_ADDRESS_COMPARE, a1);
      wr(slc_pkg::REG_SECOND_DATA_ADDRESS_COMPARE, a2);
      run(rs(0, 0, 1, 1), a1, 1, 0, 1, 0);
      run(rs(0, 0, 1, 1) | INTERNAL_DEBUG_MODE_BIT, a1, 0, 1, 1, 0);
      run(rs(0, 0, 1, 1), a1 + 32'h4, 1, 0, 0, 0);
      run(rs(1, 0, 1, 1), a2, 0, 0, 1, 0);
      run(rs(0, 1, 1, 1) | HX, a1, 1, 1, 0, 1);
      run(rs(0, 1, 1, 1) | HX, a1, 1, 0, 0, 0);
      run(rs(0, 1, 1, 1) | HX & ~(32'h1 << slc_pkg::C_EDM), a1,
          1, 1, 0, 0);
      run(rs(0, 0, 1, 0), a1, 0, 0, 0, 0);
      run(rs(0, 0, 1, 0) | rs(1, 0, 0, 1), a2, 0, 0, 1, 0);
      // Random addresses between the limits must pass unseen.
      repeat (20) begin
         run(rs(0, 0, 1, 1) | rs(1, 1, 1, 1) | HX,
             a1 + 32'h4 + (32'($urandom_range(60)) << 2),
             1'($urandom_range(1)), 1, 0, 0);
      end
      wr(slc_pkg::REG_SECOND_DATA_ADDRESS_COMPARE, a1);
      run(rs(0, 0, 1, 1) | rs(1, 1, 1, 1) | HX, a1, 1, 1, 1, 0);
      // Normal compare in internal mode raises the debug interrupt.
      wr(slc_pkg::REG_CTRL, (rs(0, 0, 1, 1) & ~(32'h1 << slc_pkg::C_SL)) |
         (32'h1 << slc_pkg::C_EVT) | INTERNAL_DEBUG_MODE_BIT);
      slc_pipe_model_inst.access(a1, $urandom, $urandom, 1'b0, 1'b1, 1'b0,
         1'b0, 0);
      #1;
      chk(32'(dirq), 32'h1);
      rd(slc_pkg::REG_STAT, rv);
      chk(32'(rv[4:0]), 32'h1);
      results();
   end

endmodule : tb
`default_nettype wire

// ---- verilog/slc_stack_limit_checker.sv ----
// Local design decisions: the register addresses and the strobed register port.
`default_nettype none

module slc_stack_limit_checker (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Register port.
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [31:0] o_rdata,
   // Load and store pipeline.
   input wire slc_pkg::slc_ls_t i_ls,
   input wire logic i_ls_done,
   input wire logic i_hi_pend,
   // Responses.
   output logic o_abort,
   output logic o_dsi,
   output logic o_mchk,
   output logic [31:0] o_mc_saved_pc,
   output logic o_dac_event,
   output logic o_halt_req,
   output logic o_watchpoint,
   output logic o_debug_irq
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] ctrl_q;
   logic [31:0] dac_q [2];
   logic [31:0] dvc_q;
   logic [4:0] stat_q, stat_d;
   logic [1:0] ext_pend_q, ext_pend_d;
   logic dbg_pend_q, dbg_pend_d;
   logic [31:0] rdata_d;

   logic [1:0] raw_hit, sw_hit, hw_hit, norm_hit;
   logic [1:0] ext_new, ext_fire, int_new;
   logic any_sw, external_debug_mode_bit, internal_debug_mode_bit, in_range, dval_ok;
   logic wr_ctrl, wr_first_data_address_compare, wr_second_data_address_compare, wr_stat, wr_dvc;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Writes are one cycle wide; every mapped write lands next edge.
   assign wr_ctrl = i_we && (i_addr == slc_pkg::REG_CTRL);
   assign wr_first_data_address_compare = i_we && (i_addr == slc_pkg::REG_FIRST_DATA_ADDRESS_COMPARE);
   assign wr_second_data_address_compare = i_we && (i_addr == slc_pkg::REG_SECOND_DATA_ADDRESS_COMPARE);
   assign wr_stat = i_we && (i_addr == slc_pkg::REG_STAT);
   assign wr_dvc = i_we && (i_addr == slc_pkg::REG_DVC);

   // Unmapped addresses read as zero, reads have no side effect.
   assign rdata_d =
      !i_re ? 32'h0000_0000 :
      (i_addr == slc_pkg::REG_CTRL) ? ctrl_q :
      (i_addr == slc_pkg::REG_FIRST_DATA_ADDRESS_COMPARE) ? dac_q[0] :
      (i_addr == slc_pkg::REG_SECOND_DATA_ADDRESS_COMPARE) ? dac_q[1] :
      (i_addr == slc_pkg::REG_STAT) ? {27'h0000000, stat_q} :
      (i_addr == slc_pkg::REG_DVC) ? dvc_q : 32'h0000_0000;

   // ****************************************************************
   // Compare resources
   // ****************************************************************
   assign external_debug_mode_bit = ctrl_q[slc_pkg::C_EDM];
   assign internal_debug_mode_bit = ctrl_q[slc_pkg::C_IDM];
   // The address set spans the two compare values, inclusive.
   assign in_range = (i_ls.addr >= dac_q[0]) && (i_ls.addr <= dac_q[1]);
   assign dval_ok = !ctrl_q[slc_pkg::C_DVAL] || (i_ls.data == dvc_q);

   for (genvar n = 0; n < 2; n++) begin : g_res
      logic type_ok, mode_ok, exact, norm_match;
      assign type_ok = i_ls.is_store ? ctrl_q[slc_pkg::C_WR + n]
                                     : ctrl_q[slc_pkg::C_RD + n];
      assign mode_ok = i_ls.supervisor ? ctrl_q[slc_pkg::C_SUP + n]
                                       : ctrl_q[slc_pkg::C_USR + n];
      assign exact = (i_ls.addr == dac_q[n]);
      assign raw_hit[n] = i_ls.valid && ctrl_q[slc_pkg::C_EN + n]
                          && type_ok && mode_ok;
      // software stack hit, no mode bit needed.
      assign sw_hit[n] = raw_hit[n] && exact && ctrl_q[slc_pkg::C_SL + n]
                         && !ctrl_q[slc_pkg::C_HW + n];
      // hardware stack hit needs the stack pointer gpr.
      assign hw_hit[n] = raw_hit[n] && exact && ctrl_q[slc_pkg::C_SL + n]
                         && ctrl_q[slc_pkg::C_HW + n] && external_debug_mode_bit
                         && i_ls.base_r1;
      // normal compare, exact or set, optional data value.
      assign norm_match = (ctrl_q[slc_pkg::C_RANGE] ? in_range : exact)
                          && dval_ok;
      assign norm_hit[n] = raw_hit[n] && norm_match
                           && !ctrl_q[slc_pkg::C_SL + n]
                           && ctrl_q[slc_pkg::C_EVT] && (external_debug_mode_bit || internal_debug_mode_bit);
   end

   assign any_sw = |sw_hit;
   assign ext_new = any_sw ? 2'b00 : (hw_hit | (norm_hit & {2{external_debug_mode_bit}}));
   // External events complete only once the access is done.
   assign ext_fire = (ext_pend_q | ext_new) & {2{i_ls_done}};
   assign ext_pend_d = (ext_pend_q | ext_new) & ~ext_fire;
   // Internal mode compare hits go to the debug status register.
   assign int_new = any_sw ? 2'b00 : (norm_hit & {2{internal_debug_mode_bit && !external_debug_mode_bit}});

   // ****************************************************************
   // Status and debug interrupt
   // ****************************************************************
   // software violations touch only their own flag.
   // A set in the same cycle as a clear wins, so no event is lost.
   assign stat_d = (stat_q & ~(wr_stat ? i_wdata[4:0] : 5'h00))
                   | {any_sw, ext_fire, int_new};
   // hold the interrupt until nothing higher is pending.
   assign dbg_pend_d = (dbg_pend_q || (|int_new)) && i_hi_pend;

   // Configuration registers.
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ctrl_q <= slc_pkg::CTRL_RST;
         dac_q[0] <= slc_pkg::DAC_RST;
         dac_q[1] <= slc_pkg::DAC_RST;
         dvc_q <= slc_pkg::DAC_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= i_wdata;
         if (wr_first_data_address_compare) dac_q[0] <= i_wdata;
         if (wr_second_data_address_compare) dac_q[1] <= i_wdata;
         if (wr_dvc) dvc_q <= i_wdata;
      end
   end

   // Event state and read data.
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         stat_q <= slc_pkg::STAT_RST;
         ext_pend_q <= 2'b00;
         dbg_pend_q <= 1'b0;
         o_rdata <= 32'h0000_0000;
      end else begin
         stat_q <= stat_d;
         ext_pend_q <= ext_pend_d;
         dbg_pend_q <= dbg_pend_d;
         o_rdata <= rdata_d;
      end
   end

   // ****************************************************************
   // Responses to the pipeline
   // ****************************************************************
   // abort with storage interrupt or machine check.
   // external event, halt or watchpoint after completion.
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_abort <= 1'b0;
         o_dsi <= 1'b0;
         o_mchk <= 1'b0;
         o_mc_saved_pc <= 32'h0000_0000;
         o_dac_event <= 1'b0;
         o_halt_req <= 1'b0;
         o_watchpoint <= 1'b0;
         o_debug_irq <= 1'b0;
      end else begin
         o_abort <= any_sw;
         o_dsi <= any_sw && !i_ls.mc_mode;
         o_mchk <= any_sw && i_ls.mc_mode;
         if (any_sw && i_ls.mc_mode) o_mc_saved_pc <= i_ls.pc;
         o_dac_event <= |ext_fire;
         o_halt_req <= (|ext_fire) && ctrl_q[slc_pkg::C_HALT];
         o_watchpoint <= (|ext_fire) && ctrl_q[slc_pkg::C_WP];
         o_debug_irq <= (dbg_pend_q || (|int_new)) && !i_hi_pend;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // software stack hit aborts.
   sw_abort_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (|sw_hit) |=> o_abort)
      else $error("software stack hit did not abort");

   // no hardware stack hit outside external mode.
   hw_needs_edm_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      !external_debug_mode_bit |-> hw_hit == 2'b00)
      else $error("hardware stack hit without external mode");

   // no compare event from a software violation alone.
   sw_no_event_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (any_sw && ext_pend_q == 2'b00) |=> !o_dac_event)
      else $error("software violation produced compare event");

   // exactly one of the two exceptions on abort.
   sw_excl_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      o_abort |-> (o_dsi ^ o_mchk))
      else $error("abort without one exception kind");

   // saved pc is the offending access.
   mc_pc_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (any_sw && i_ls.mc_mode) |=> o_mc_saved_pc == $past(i_ls.pc))
      else $error("machine check saved pc wrong");

   // hardware hit requires the stack pointer base.
   hw_r1_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (hw_hit != 2'b00) |-> i_ls.base_r1)
      else $error("hardware hit without stack pointer base");

   ext_done_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      o_dac_event |-> $past(i_ls_done) && (stat_q[3:2] != 2'b00))
      else $error("external event before access completion");

   sw_wins_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (any_sw && ext_pend_q == 2'b00) |=> ext_pend_q == 2'b00)
      else $error("hardware event kept alongside software hit");

   // no debug interrupt while higher exception pends.
   irq_prio_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      o_debug_irq |-> !$past(i_hi_pend))
      else $error("debug interrupt over higher priority");

   // no abort without a software stack hit.
   abort_src_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      !any_sw |=> !o_abort)
      else $error("abort without software stack hit");

   // storage interrupt outside machine check mode.
   dsi_mode_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (any_sw && !i_ls.mc_mode) |=> o_dsi)
      else $error("storage interrupt missing");

   // machine check in machine check mode.
   mchk_mode_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (any_sw && i_ls.mc_mode) |=> o_mchk)
      else $error("machine check missing");

   // software violation sets no compare status.
   sw_no_stat_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      any_sw |-> int_new == 2'b00)
      else $error("software violation set compare status");

   // halt request only with a compare event.
   halt_evt_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      o_halt_req |-> o_dac_event)
      else $error("halt request without compare event");

   // watchpoint only with a compare event.
   wp_evt_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      o_watchpoint |-> o_dac_event)
      else $error("watchpoint without compare event");

   // a completed external hit gives the event.
   evt_fire_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (|ext_fire) |=> o_dac_event)
      else $error("external hit gave no compare event");

   // halt follows the event when enabled.
   halt_fire_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      ((|ext_fire) && ctrl_q[slc_pkg::C_HALT]) |=> o_halt_req)
      else $error("enabled halt request missing");

   // an external hit waits for completion.
   hw_wait_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      ((ext_new != 2'b00) && !i_ls_done) |=> ext_pend_q != 2'b00)
      else $error("external hit lost before completion");

   // a software stack hit on either resource records the violation.
   any_res_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (|sw_hit) |=> stat_q[slc_pkg::S_SWV])
      else $error("violation flag not set");

   // no new hardware event beside a software hit.
   sw_drop_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      any_sw |-> ext_new == 2'b00)
      else $error("hardware event beside software hit");

   // stack hits only at the exact limits.
   exact_only_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (|sw_hit) |-> (i_ls.addr == dac_q[0] || i_ls.addr == dac_q[1]))
      else $error("stack hit off the limit address");

   // normal compares only with events enabled.
   norm_evt_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (|norm_hit) |-> ctrl_q[slc_pkg::C_EVT])
      else $error("normal compare with events off");

   // interrupt raised when nothing higher pends.
   irq_free_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      ((|int_new) && !i_hi_pend) |=> o_debug_irq)
      else $error("debug interrupt not raised");

   irq_hold_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      (dbg_pend_q && i_hi_pend) |=> dbg_pend_q)
      else $error("blocked debug interrupt dropped");

   // first resource honours its privilege bits.
   priv_sel_a: assert property (
      @(posedge i_clk_sys) disable iff (i_srst)
      sw_hit[0] |-> (i_ls.supervisor ? ctrl_q[slc_pkg::C_SUP]
                                     : ctrl_q[slc_pkg::C_USR]))
      else $error("stack hit of wrong privilege");

endmodule : slc_stack_limit_checker
`default_nettype wire
